// *** design/gpio_fsel_pkg.sv ***
// Constants, register map and carrier types for the pin function and output block
package gpio_fsel_pkg;

	// Pin population and field geometry
	localparam int NUM_PINS  = 58;          // Pins 0 to 57
	localparam int NUM_ALT   = 6;           // Alternate functions 0 to 5
	localparam int FSEL_W    = 3;           // Bits per function field
	localparam int LOW_PINS  = 40;          // Pins whose fields live in other banks
	localparam int SEL4_PINS = 10;          // Pins 40 to 49
	localparam int SEL5_PINS = 8;           // Pins 50 to 57
	localparam int SEL4_W    = SEL4_PINS * FSEL_W;  // Bits 29:0
	localparam int SEL5_W    = SEL5_PINS * FSEL_W;  // Bits 23:0
	localparam int LOW_BANK  = 32;          // Pins 0 to 31
	localparam int HIGH_BANK = 26;          // Pins 32 to 57, bits 25:0
	localparam int DATA_W    = 32;

	// Function codes
	localparam logic [2:0] FUNC_INPUT  = 3'h0;
	localparam logic [2:0] FUNC_OUTPUT = 3'h1;
	localparam logic [2:0] FUNC_ALT0   = 3'h4;
	localparam logic [2:0] FUNC_ALT1   = 3'h5;
	localparam logic [2:0] FUNC_ALT2   = 3'h6;
	localparam logic [2:0] FUNC_ALT3   = 3'h7;
	localparam logic [2:0] FUNC_ALT4   = 3'h3;
	localparam logic [2:0] FUNC_ALT5   = 3'h2;

	// Register byte offsets
	localparam logic [7:0] OFS_FSEL_40_49 = 8'h10;
	localparam logic [7:0] OFS_FSEL_50_57 = 8'h14;
	localparam logic [7:0] OFS_SET_LOW    = 8'h1c;
	localparam logic [7:0] OFS_SET_HIGH   = 8'h20;
	localparam logic [7:0] OFS_CLR_LOW    = 8'h28;
	localparam logic [7:0] OFS_CLR_HIGH   = 8'h2c;
	localparam logic [7:0] OFS_LEVEL_LOW  = 8'h34;
	localparam logic [7:0] OFS_LEVEL_HIGH = 8'h38;

	// Reset values
	localparam logic [SEL4_W-1:0]   RST_CODES_40_49 = 30'h0;
	localparam logic [SEL5_W-1:0]   RST_CODES_50_57 = 24'h0;
	localparam logic [NUM_PINS-1:0] RST_LATCH = 58'h0;

	// Register port request
	typedef struct packed {
		logic [7:0]        addr;   // Byte address
		logic [DATA_W-1:0] wdata;  // Write data
		logic              wr;     // Write strobe
		logic              rd;     // Read strobe
	} reg_req_t;

	// Whole state of the top block
	typedef struct packed {
		logic [SEL4_W-1:0]   codes_40_49;  // Fields of pins 40 to 49
		logic [SEL5_W-1:0]   codes_50_57;  // Fields of pins 50 to 57
		logic [NUM_PINS-1:0] latch;    // Output latches
		logic [NUM_PINS-1:0] pad_out;  // Registered pad level
		logic [NUM_PINS-1:0] pad_oe;   // Registered pad enable
		logic [DATA_W-1:0]   rdata;    // Read data
	} gpio_state_t;

	// True when a code hands the pin to a peripheral
	function automatic logic is_alt(input logic [2:0] code);
		return code[2] | code[1];
	endfunction

	// Peripheral index for an alternate code
	function automatic logic [2:0] alt_index(input logic [2:0] code);
		logic [2:0] idx;
		unique case (code)
			FUNC_ALT0: idx = 3'h0;
			FUNC_ALT1: idx = 3'h1;
			FUNC_ALT2: idx = 3'h2;
			FUNC_ALT3: idx = 3'h3;
			FUNC_ALT4: idx = 3'h4;
			FUNC_ALT5: idx = 3'h5;
			default:   idx = 3'h0;
		endcase
		return idx;
	endfunction

endpackage

// *** design/pin_func_mux.sv ***
// Per-pin driver selection from a function code
`timescale 1ns/100ps

module pin_func_mux
	import gpio_fsel_pkg::*;
(
	// Function code of this pin
	input  wire logic [2:0]         code,
	// Output latch of this pin
	input  wire logic               latch,
	// Peripheral drive for this pin
	input  wire logic [NUM_ALT-1:0] alt_out,
	input  wire logic [NUM_ALT-1:0] alt_oe,
	// Resulting pad drive
	output logic                    drive,
	output logic                    drive_en
);

	// Pick the owner of the pad
	always_comb begin
		drive    = 1'b0;
		drive_en = 1'b0;
		if (code == FUNC_OUTPUT) begin
			// Latch drives the pad
			drive    = latch;
			drive_en = 1'b1;
		end else if (is_alt(code)) begin
			// Peripheral owns level and direction
			drive    = alt_out[alt_index(code)];
			drive_en = alt_oe[alt_index(code)];
		end
	end

endmodule

// *** design/gpio_fsel_top.sv ***
// Function select, output set and clear, and pad drive for a bank of pins
`timescale 1ns/100ps

// Notes on behaviour
// R01: 000 input undriven, 001 output from latch
// R02: Other codes route one of six peripherals
// R03: Pins 40-49 packed low first, 31:30 reserved
// R04: Pins 50-57 packed low first, 31:24 reserved
// R05: All function fields reset to input
// R06: Set writes raise latches where ones written
// R07: Clear writes lower latches where ones written
// R08: Input pins keep latch; output shows last value
// R09: Only bits written as one change
// R10: Low set/clear bit n acts on pin n
// R11: High set bits 25:0 act on pins 32-57
// R12: High clear bits 25:0 act on pins 32-57
// R13: Level registers read actual pad levels
// R14: Alternate function drives pad, latch kept
// R15: Clear wins over simultaneous set
module gpio_fsel_top
	import gpio_fsel_pkg::*;
(
	// Clock and reset
	input  wire logic                           mclk,
	input  wire logic                           sys_rst,
	// Register port
	input  wire reg_req_t                       bus_req,
	output logic [DATA_W-1:0]                   rd_data,
	// Function fields of pins 0 to 39 from the other banks
	input  wire logic [LOW_PINS*FSEL_W-1:0]     low_codes,
	// Peripheral drive, one row per alternate function
	input  wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out,
	input  wire logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_oe,
	// Pads
	input  wire logic [NUM_PINS-1:0]            pad_in,
	output logic [NUM_PINS-1:0]                 pad_out,
	output logic [NUM_PINS-1:0]                 pad_oe
);

	// Registered state and its next value
	gpio_state_t                 s_q;
	gpio_state_t                 s_d;

	// One-cycle masks from set and clear writes
	logic [NUM_PINS-1:0]         set_mask;
	logic [NUM_PINS-1:0]         clr_mask;

	// Codes of every pin, pin n at bits 3n+2:3n
	logic [NUM_PINS*FSEL_W-1:0]  all_codes;

	// Pad drive chosen per pin before registering
	logic [NUM_PINS-1:0]         mux_out;
	logic [NUM_PINS-1:0]         mux_oe;

	// Peripheral rows regrouped per pin
	logic [NUM_PINS-1:0][NUM_ALT-1:0] alt_out_pin;
	logic [NUM_PINS-1:0][NUM_ALT-1:0] alt_oe_pin;

	// Address match, used by both write and read decode
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	// Field concatenation, pins 40 up sit above the other banks
	// Pins 0 to 39 arrive already chosen by the banks that own them
	assign all_codes = {s_q.codes_50_57, s_q.codes_40_49, low_codes};  // [R03] [R04]

	// Outputs straight from flip-flops
	assign rd_data = s_q.rdata;
	assign pad_out = s_q.pad_out;
	assign pad_oe  = s_q.pad_oe;

	// One selector per pin
	genvar p;
	genvar a;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_pin
			// Transpose the peripheral rows for this pin
			for (a = 0; a < NUM_ALT; a++) begin : g_alt
				assign alt_out_pin[p][a] = alt_out[a][p];
				assign alt_oe_pin[p][a]  = alt_oe[a][p];
			end
			// Latch or peripheral onto the pad
			pin_func_mux u_mux (
				.code     (all_codes[p*FSEL_W +: FSEL_W]),  // [R01] [R02]
				.latch    (s_q.latch[p]),                    // [R08]
				.alt_out  (alt_out_pin[p]),                  // [R14]
				.alt_oe   (alt_oe_pin[p]),
				.drive    (mux_out[p]),
				.drive_en (mux_oe[p])
			);
		end
	endgenerate

	// Write masks; only one write per cycle, so masks come from one register
	always_comb begin
		set_mask = '0;
		clr_mask = '0;
		if (bus_req.wr) begin
			if (hit(bus_req.addr, OFS_SET_LOW)) begin
				set_mask[LOW_BANK-1:0] = bus_req.wdata;  // [R06] [R10]
			end
			if (hit(bus_req.addr, OFS_SET_HIGH)) begin
				// Bits 31:26 dropped, they reach no pin
				set_mask[NUM_PINS-1:LOW_BANK] = bus_req.wdata[HIGH_BANK-1:0];  // [R11]
			end
			if (hit(bus_req.addr, OFS_CLR_LOW)) begin
				clr_mask[LOW_BANK-1:0] = bus_req.wdata;  // [R07] [R10]
			end
			if (hit(bus_req.addr, OFS_CLR_HIGH)) begin
				clr_mask[NUM_PINS-1:LOW_BANK] = bus_req.wdata[HIGH_BANK-1:0];  // [R12]
			end
		end
	end

	// Next state
	always_comb begin
		s_d = s_q;
		// Read data stand only in the cycle after the strobe
		s_d.rdata = '0;
		// Function field writes, reserved bits discarded
		if (bus_req.wr && hit(bus_req.addr, OFS_FSEL_40_49)) begin
			s_d.codes_40_49 = bus_req.wdata[SEL4_W-1:0];  // [R03]
		end
		if (bus_req.wr && hit(bus_req.addr, OFS_FSEL_50_57)) begin
			s_d.codes_50_57 = bus_req.wdata[SEL5_W-1:0];  // [R04]
		end
		// Latches update whatever the function; clear applied last wins
		s_d.latch = (s_q.latch | set_mask) & ~clr_mask;  // [R09] [R15] [R08]
		// Pad drive registered so the pads never see decode glitches
		s_d.pad_out = mux_out;  // [R14]
		s_d.pad_oe  = mux_oe;   // [R01]
		// Read decode; write-only and unmapped words read zero
		if (bus_req.rd) begin
			if (hit(bus_req.addr, OFS_FSEL_40_49)) begin
				s_d.rdata = {2'h0, s_q.codes_40_49};  // [R03]
			end else if (hit(bus_req.addr, OFS_FSEL_50_57)) begin
				s_d.rdata = {8'h00, s_q.codes_50_57};  // [R04]
			end else if (hit(bus_req.addr, OFS_LEVEL_LOW)) begin
				s_d.rdata = pad_in[LOW_BANK-1:0];  // [R13]
			end else if (hit(bus_req.addr, OFS_LEVEL_HIGH)) begin
				s_d.rdata = {6'h00, pad_in[NUM_PINS-1:LOW_BANK]};  // [R13]
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			// Pins 40 to 57 start as inputs, and every pad starts undriven
			// Constants only, so a release never loads a half-settled value
			s_q.codes_40_49 <= RST_CODES_40_49;  // [R05]
			s_q.codes_50_57 <= RST_CODES_50_57;  // [R05]
			s_q.latch       <= RST_LATCH;
			s_q.pad_out <= '0;
			s_q.pad_oe  <= '0;
			s_q.rdata   <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Checks share one clock and reset
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	// Checks on every pin of the bank
	// They look at the code the selector sees, not at the field register,
	// so pins 0 to 39 with codes from the other banks are covered too
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_chk
			// Input code leaves the pad undriven
			a_input_no_drive: assert property ( // [R01]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_INPUT |=> !pad_oe[p])
				else $error("input pin driven");
			// Output code drives the latch value
			a_output_from_latch: assert property ( // [R08]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_OUTPUT
				|=> pad_oe[p] && pad_out[p] == $past(s_q.latch[p]))
				else $error("output pin not showing latch");
			// Code 010 hands the pad to peripheral 5
			a_alt_five_route: assert property ( // [R02]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_ALT5
				|=> pad_out[p] == $past(alt_out[5][p]) && pad_oe[p] == $past(alt_oe[5][p]))
				else $error("alternate 5 not routed");
			// Code 100 hands the pad to peripheral 0
			a_alt_zero_route: assert property ( // [R14]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_ALT0
				|=> pad_out[p] == $past(alt_out[0][p]) && pad_oe[p] == $past(alt_oe[0][p]))
				else $error("alternate 0 not routed");
			// Code 101 hands the pad to peripheral 1
			a_alt_one_route: assert property ( // [R02]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_ALT1
				|=> pad_out[p] == $past(alt_out[1][p]) && pad_oe[p] == $past(alt_oe[1][p]))
				else $error("alternate 1 not routed");
			// Code 110 hands the pad to peripheral 2
			a_alt_two_route: assert property ( // [R02]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_ALT2
				|=> pad_out[p] == $past(alt_out[2][p]) && pad_oe[p] == $past(alt_oe[2][p]))
				else $error("alternate 2 not routed");
			// Code 111 hands the pad to peripheral 3
			a_alt_three_route: assert property ( // [R02]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_ALT3
				|=> pad_out[p] == $past(alt_out[3][p]) && pad_oe[p] == $past(alt_oe[3][p]))
				else $error("alternate 3 not routed");
			// Code 011 hands the pad to peripheral 4
			a_alt_four_route: assert property ( // [R02]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_ALT4
				|=> pad_out[p] == $past(alt_out[4][p]) && pad_oe[p] == $past(alt_oe[4][p]))
				else $error("alternate 4 not routed");
			// Peripheral ownership leaves the latch to set and clear only
			a_alt_latch_kept: assert property ( // [R14]
				is_alt(all_codes[p*FSEL_W +: FSEL_W]) && !set_mask[p] && !clr_mask[p]
				|=> s_q.latch[p] == $past(s_q.latch[p]))
				else $error("latch moved under peripheral");
			// A set written while the pin is an input is still remembered
			a_input_set_kept: assert property ( // [R08]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_INPUT && set_mask[p] && !clr_mask[p]
				|=> s_q.latch[p])
				else $error("set lost on input pin");
			// A clear written while the pin is an input is remembered too
			a_input_clear_kept: assert property ( // [R08]
				all_codes[p*FSEL_W +: FSEL_W] == FUNC_INPUT && clr_mask[p]
				|=> !s_q.latch[p])
				else $error("clear lost on input pin");
		end
	endgenerate

	// Low set raises written bits, keeps the rest
	a_set_low_bits: assert property ( // [R06]
		bus_req.wr && bus_req.addr == OFS_SET_LOW
		|=> s_q.latch[LOW_BANK-1:0] == ($past(s_q.latch[LOW_BANK-1:0]) | $past(bus_req.wdata)))
		else $error("low set wrong");

	// Low clear lowers written bits, keeps the rest
	a_clear_low_bits: assert property ( // [R07]
		bus_req.wr && bus_req.addr == OFS_CLR_LOW
		|=> s_q.latch[LOW_BANK-1:0] == ($past(s_q.latch[LOW_BANK-1:0]) & ~$past(bus_req.wdata)))
		else $error("low clear wrong");

	// High set maps bit 0 to pin 32
	a_set_high_bits: assert property ( // [R11]
		bus_req.wr && bus_req.addr == OFS_SET_HIGH
		|=> s_q.latch[NUM_PINS-1:LOW_BANK]
			== ($past(s_q.latch[NUM_PINS-1:LOW_BANK]) | $past(bus_req.wdata[HIGH_BANK-1:0])))
		else $error("high set wrong");

	// High clear maps bit 0 to pin 32
	a_clear_high_bits: assert property ( // [R12]
		bus_req.wr && bus_req.addr == OFS_CLR_HIGH
		|=> s_q.latch[NUM_PINS-1:LOW_BANK]
			== ($past(s_q.latch[NUM_PINS-1:LOW_BANK]) & ~$past(bus_req.wdata[HIGH_BANK-1:0])))
		else $error("high clear wrong");

	// A low-bank write leaves the high bank alone
	a_other_bank_kept: assert property ( // [R09]
		bus_req.wr && (bus_req.addr == OFS_SET_LOW || bus_req.addr == OFS_CLR_LOW)
		|=> $stable(s_q.latch[NUM_PINS-1:LOW_BANK]))
		else $error("other bank disturbed");

	// A high-bank write leaves the low bank alone
	a_low_bank_kept: assert property ( // [R09]
		bus_req.wr && (bus_req.addr == OFS_SET_HIGH || bus_req.addr == OFS_CLR_HIGH)
		|=> $stable(s_q.latch[LOW_BANK-1:0]))
		else $error("low bank disturbed");

	// Bits 31:26 of the high set word reach no pin
	a_set_high_reserved: assert property ( // [R11]
		bus_req.wr && bus_req.addr == OFS_SET_HIGH && bus_req.wdata[HIGH_BANK-1:0] == '0
		|=> $stable(s_q.latch))
		else $error("reserved set bits acted");

	// Field write then read back, reserved bits zero
	a_codes_readback: assert property ( // [R03]
		bus_req.wr && bus_req.addr == OFS_FSEL_40_49 ##1 bus_req.rd && bus_req.addr == OFS_FSEL_40_49
		|=> rd_data == {2'h0, $past(bus_req.wdata[SEL4_W-1:0], 2)})
		else $error("function field 40-49 readback wrong");

	// Top two bits of the 40-49 word never read set
	a_codes_low_reserved: assert property ( // [R03]
		bus_req.rd && bus_req.addr == OFS_FSEL_40_49 |=> rd_data[31:30] == 2'h0)
		else $error("function field 40-49 reserved bits set");

	// Field write then read back for pins 50 to 57
	a_codes_high_readback: assert property ( // [R04]
		bus_req.wr && bus_req.addr == OFS_FSEL_50_57 ##1 bus_req.rd && bus_req.addr == OFS_FSEL_50_57
		|=> rd_data == {8'h00, $past(bus_req.wdata[SEL5_W-1:0], 2)})
		else $error("function field 50-57 readback wrong");

	// Upper byte of the 50-57 word never reads set
	a_codes_reserved: assert property ( // [R04]
		bus_req.rd && bus_req.addr == OFS_FSEL_50_57 |=> rd_data[31:24] == 8'h00)
		else $error("function field 50-57 reserved bits set");

	// A 50-57 field write keeps the 40-49 fields
	a_bank_fields_apart: assert property ( // [R04]
		bus_req.wr && bus_req.addr == OFS_FSEL_50_57 |=> $stable(s_q.codes_40_49))
		else $error("function field 40-49 disturbed");

	// Function fields move only on their own write
	a_codes_hold: assert property ( // [R05]
		!(bus_req.wr && (bus_req.addr == OFS_FSEL_40_49 || bus_req.addr == OFS_FSEL_50_57))
		|=> $stable(s_q.codes_40_49) && $stable(s_q.codes_50_57))
		else $error("function field changed without write");

	// A write to the level words changes nothing
	a_level_write_ignored: assert property ( // [R13]
		bus_req.wr && (bus_req.addr == OFS_LEVEL_LOW || bus_req.addr == OFS_LEVEL_HIGH)
		|=> $stable(s_q.latch) && $stable(s_q.codes_40_49) && $stable(s_q.codes_50_57))
		else $error("level write changed state");

	// High level word carries pins 32 to 57 in bits 25:0
	a_level_high_read: assert property ( // [R13]
		bus_req.rd && bus_req.addr == OFS_LEVEL_HIGH
		|=> rd_data == {6'h00, $past(pad_in[NUM_PINS-1:LOW_BANK])})
		else $error("high level read wrong");

	// Set and clear words are write-only and read as zero
	a_write_only_zero: assert property ( // [R06] [R07]
		bus_req.rd && (bus_req.addr == OFS_SET_LOW || bus_req.addr == OFS_SET_HIGH
			|| bus_req.addr == OFS_CLR_LOW || bus_req.addr == OFS_CLR_HIGH)
		|=> rd_data == '0)
		else $error("write-only word read nonzero");

	// Level read shows the pads of the strobe cycle
	a_level_readback: assert property ( // [R13]
		bus_req.rd && bus_req.addr == OFS_LEVEL_LOW |=> rd_data == $past(pad_in[LOW_BANK-1:0]))
		else $error("level read wrong");

	// Data never linger past the answer cycle
	a_read_one_cycle: assert property (
		!bus_req.rd |=> rd_data == '0)
		else $error("read data held");

endmodule

// *** tb/pad_partner.sv ***
// Pads and alternate-function peripherals beyond the block
`timescale 1ns/100ps

module pad_partner
	import gpio_fsel_pkg::*;
(
	// Clock and reset
	input  wire logic                             mclk,
	input  wire logic                             sys_rst,
	// Drive from the block
	input  wire logic [NUM_PINS-1:0]              pad_out,
	input  wire logic [NUM_PINS-1:0]              pad_oe,
	// Levels back to the block
	output logic [NUM_PINS-1:0]                   pad_in,
	// Peripheral drive rows
	output logic [NUM_ALT-1:0][NUM_PINS-1:0]      alt_out,
	output logic [NUM_ALT-1:0][NUM_PINS-1:0]      alt_oe
);
	logic [NUM_PINS-1:0] pat_q;  // Free-running pattern

	// Undriven pads flip each cycle, so a stale level never passes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pad_in <= '0;
			pat_q  <= 58'h1;
		end else begin
			pad_in <= (pad_oe & pad_out) | (~pad_oe & ~pad_in);
			pat_q  <= {pat_q[56:0], ~(pat_q[57] ^ pat_q[40])};
		end
	end

	// Each peripheral sees its own rotation, so a wrong row shows
	always_comb begin
		for (int i = 0; i < NUM_ALT; i++) begin
			alt_out[i] = (pat_q << i) | (pat_q >> (NUM_PINS - i));
			alt_oe[i]  = alt_out[i] ^ (pat_q >> (i + 1));
		end
	end
endmodule

// *** tb/tb.sv ***
// Self-checking bench with a reference model of the block
`timescale 1ns/100ps

module tb;
	import gpio_fsel_pkg::*;
	logic                             mclk = 1'b0;      // Clock
	logic                             sys_rst = 1'b1;   // Reset
	reg_req_t                         bus_req = '0;     // Register port
	logic [LOW_PINS*FSEL_W-1:0]       low_codes = '0;   // Other banks
	logic [DATA_W-1:0]                rd_data;          // Read data
	logic [NUM_ALT-1:0][NUM_PINS-1:0] alt_out, alt_oe;  // Peripherals
	logic [NUM_PINS-1:0]              pad_in, pad_out, pad_oe;
	int                               code_m [NUM_PINS];  // Model codes
	logic [NUM_PINS-1:0]              lat_m, exp_out, exp_oe;
	logic [DATA_W-1:0]                exp_rd;           // Expected read
	logic [127:0]                     r128;             // Random codes
	logic [7:0]                       addrs [10] = '{8'h10, 8'h14, 8'h1c, 8'h20, 8'h28, 8'h2c, 8'h34, 8'h38,
		8'h3c, 8'h00};                                  // Mapped and unmapped
	int                               mismatches = 0, checks = 0, seed = 80113, c, k;
	int                               kind, pick;       // Stimulus choices
	logic                             hi, bit_w;

	// Free-running 100 MHz clock
	always #5 mclk = ~mclk;

	gpio_fsel_top dut (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
		.low_codes(low_codes), .alt_out(alt_out), .alt_oe(alt_oe), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe));
	pad_partner far_side (.mclk(mclk), .sys_rst(sys_rst), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_in(pad_in), .alt_out(alt_out), .alt_oe(alt_oe));

	// Model: expectations use state before this edge's write lands
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			foreach (code_m[p]) code_m[p] = 0;
			lat_m = '0;
			exp_out = '0;
			exp_oe = '0;
			exp_rd = '0;
		end else begin
			exp_rd = '0;
			for (int p = 0; p < NUM_PINS; p++) begin
				c = (p < LOW_PINS) ? int'(low_codes[3*p+:3]) : code_m[p];
				k = (c > 3) ? c - 4 : 7 - c;
				exp_oe[p] = (c == 1) ? 1'b1 : (c > 1) ? alt_oe[k][p] : 1'b0;
				exp_out[p] = (c == 1) ? lat_m[p] : (c > 1) ? alt_out[k][p] : 1'b0;
				if (bus_req.rd && bus_req.addr == OFS_FSEL_40_49 && p >= 40 && p < 50)
					exp_rd[3*(p-40)+:3] = 3'(code_m[p]);
				if (bus_req.rd && bus_req.addr == OFS_FSEL_50_57 && p >= 50)
					exp_rd[3*(p-50)+:3] = 3'(code_m[p]);
				if (bus_req.wr && bus_req.addr == OFS_FSEL_40_49 && p >= 40 && p < 50)
					code_m[p] = int'(bus_req.wdata[3*(p-40)+:3]);
				if (bus_req.wr && bus_req.addr == OFS_FSEL_50_57 && p >= 50)
					code_m[p] = int'(bus_req.wdata[3*(p-50)+:3]);
				hi = (p >= LOW_BANK);
				bit_w = bus_req.wr && bus_req.wdata[hi ? p - LOW_BANK : p];
				if (bit_w && bus_req.addr == (hi ? OFS_SET_HIGH : OFS_SET_LOW)) lat_m[p] = 1'b1;
				if (bit_w && bus_req.addr == (hi ? OFS_CLR_HIGH : OFS_CLR_LOW)) lat_m[p] = 1'b0;
			end
			if (bus_req.rd && bus_req.addr == OFS_LEVEL_LOW) exp_rd = pad_in[31:0];
			if (bus_req.rd && bus_req.addr == OFS_LEVEL_HIGH) exp_rd = {6'h0, pad_in[57:32]};
		end
	end

	// One comparison, counted
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
		checks++;
		if (e !== s) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	// Outputs are settled at the falling edge
	always @(negedge mclk) begin
		if (!sys_rst) begin
			chk("pad_oe", 64'(exp_oe), 64'(pad_oe));
			chk("pad_out", 64'(exp_out & exp_oe), 64'(pad_out & pad_oe));
			chk("rd_data", 64'(exp_rd), 64'(rd_data));
		end
	end

	// One bus cycle, launched just after a rising edge
	task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w, input logic r);
		@(posedge mclk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
	endtask

	// Counts and verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Hang guard, well beyond the expected length
	initial begin
		repeat (3000) @(posedge mclk);
		mismatches++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		op(OFS_FSEL_40_49, 32'h0, 1'b0, 1'b1);
		op(OFS_FSEL_50_57, 32'h0, 1'b0, 1'b1);
		$display("test reset_values done");
		// Latches set while input, then pins 50..57 take every code once
		op(OFS_SET_HIGH, 32'hffffffff, 1'b1, 1'b0);
		op(OFS_FSEL_50_57, 32'hfffac688, 1'b1, 1'b0);
		op(OFS_FSEL_50_57, 32'h0, 1'b0, 1'b1);
		op(OFS_CLR_HIGH, 32'h00080000, 1'b1, 1'b0);
		op(OFS_FSEL_40_49, 32'hc0fac688, 1'b1, 1'b0);
		op(OFS_FSEL_40_49, 32'h0, 1'b0, 1'b1);
		op(8'h00, 32'h0, 1'b0, 1'b0);
		repeat (2) @(posedge mclk);
		$display("test codes done");
		// Reset in mid-run returns fields to input and drops the latches
		sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		op(OFS_FSEL_40_49, 32'h0, 1'b0, 1'b1);
		op(OFS_FSEL_50_57, 32'h0, 1'b0, 1'b1);
		op(OFS_SET_HIGH, 32'hfc000000, 1'b1, 1'b0);
		op(OFS_FSEL_50_57, 32'h00249249, 1'b1, 1'b0);
		op(8'h00, 32'h0, 1'b0, 1'b0);
		$display("test mid_reset done");
		// Random traffic, back to back, with unmapped places
		for (int i = 0; i < 800; i++) begin
			kind = {$random(seed)} % 3;
			pick = {$random(seed)} % 10;
			r128 = {$random(seed), $random(seed), $random(seed), $random(seed)};
			if (i % 16 == 0) low_codes <= r128[119:0];
			op(addrs[pick], r128[31:0], kind == 1, kind == 2);
		end
		op(8'h00, 32'h0, 1'b0, 1'b0);
		repeat (2) @(posedge mclk);
		$display("test random done");
		wrap_up();
	end
endmodule
